/* File: pzs_ctrl.sv */
// Control, status and result registers of a digital pressure sensor,
// reached over a serial link (16-bit frames, 4-wire or 3-wire).
// Assumes raw pressure, temperature and short detect come from logic on
// clk; the link clock runs only while the chip select is low.
// Notes on behaviour
// - Writing soft reset bit 1 restores all configuration to power-on values.
// - Auto reference bit copies latest pressure result into reference.
// - Following pressure results are sensor pressure minus reference.
// - Auto reference bit clears itself once the copy is done.
// - Host may write the reference bytes; that value is subtracted.
// - Measurement run bit starts continuous pressure and temperature sampling.
// - Sampling only runs while the chip-on bit is also set.
// - Rate field picks 1, 5, 11 or 23 samples per second; 000 idle.
// - Temperature rate is 1 per second for codes 1-4, else pressure rate.
// - Three-wire bit moves read data from the output pin to shared pin.
// - Reading the event source clears its non-queue flags and their hold on the interrupt pin.
// - Any-event bit reads 1 while any event flag is set.
// - Short flag set when a terminal short is seen during a measurement.
// - Queue empty and full flags follow the sample queue level.
// - Measurement done flag set when a result enters the queue.
// - Low flag set when result bits 23:16 are below low limit, signed.
// - High flag set when result bits 23:16 exceed high limit, signed.
// - Limits are signed; low resets to 0x00, high to 0xff.
// - Available flags set per new sample, clear on high byte read.
// - Overrun flags set on new data while full or available still set.
// - Pressure result is 24-bit two's complement, lsb 1/64 Pa.
// - Temperature result is a 16-bit unsigned code in two bytes.
// - Reading all three pressure bytes removes the head sample.
// - A sample arriving at a full queue drops the oldest one.
// - Mask bits, default 1, keep their events off the interrupt pin.
// - Interrupt pin active high when polarity bit is 0, else low.
`timescale 1ns/1ps
module pzs_ctrl #(
   parameter int unsigned CYC_1S_P  = pzs_pkg::CYC_1S,
   parameter int unsigned CYC_5S_P  = pzs_pkg::CYC_5S,
   parameter int unsigned CYC_11S_P = pzs_pkg::CYC_11S,
   parameter int unsigned CYC_23S_P = pzs_pkg::CYC_23S
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   output logic             sdo_o,
   output logic             sdo_oe,
   input  wire logic        sdio_i,
   output logic             sdio_o,
   output logic             sdio_oe,
   input  wire logic [23:0] raw_press_i,
   input  wire logic [15:0] raw_temp_i,
   input  wire logic        short_i,
   output logic             int_o,
   output logic             int_oe
);
   import pzs_pkg::*;

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   pzs_core_type  s, n;
   pzs_link_type  l, m;
   pzs_frame_type w;
   logic [4:0]    lcnt;
   logic [2:0]    code;
   logic [25:0]   per;
   logic [23:0]   diff, head;
   logic [5:0]    setv;
   logic          meas, ptick, ttick, fev, wr, rdv, full, pop, push;
   logic          din, rdph;

   function automatic logic [25:0] pcyc(input logic [2:0] c);
      case (c)
         3'h1:       pcyc = 26'(CYC_1S_P);
         3'h2, 3'h5: pcyc = 26'(CYC_5S_P);
         3'h3, 3'h6: pcyc = 26'(CYC_11S_P);
         3'h4, 3'h7: pcyc = 26'(CYC_23S_P);
         default:    pcyc = 26'h0;
      endcase
   endfunction : pcyc

   function automatic pzs_core_type cfg_rst(input pzs_core_type x);
      cfg_rst       = x;
      cfg_rst.ref_p = 24'h0;
      cfg_rst.ctrl0 = CTRL0_RST;
      cfg_rst.mask  = MASK_RST;
      cfg_rst.ctrl2 = CTRL2_RST;
      cfg_rst.ctrl3 = CTRL3_RST;
      cfg_rst.ths_l = THS_L_RST;
      cfg_rst.ths_h = THS_H_RST;
   endfunction : cfg_rst

   // -------------------------------------------------------------
   // Sampling schedule
   // -------------------------------------------------------------
   assign code  = s.ctrl3[6:4];
   assign per   = pcyc(code);
   assign meas  = s.ctrl3[RUN_BIT] & s.ctrl0[EN_BIT];
   assign ptick = meas && code != 3'h0 && s.pcnt >= per - 26'h1;
   assign ttick = (code >= 3'h5) ? ptick
                : meas && code != 3'h0 && s.tcnt >= 26'(CYC_1S_P - 1);
   assign push  = ptick;
   assign diff  = raw_press_i - s.ref_p;
   assign head  = s.fifo[s.rp];
   assign full  = s.cnt == FIFO_FULL;

   // Frame words arrive through a toggle handshake
   assign w     = l.hold;
   assign fev   = s.fr_s ^ s.fr_d;
   assign wr    = fev & ~w.rd;
   assign rdv   = fev & w.rd;
   assign setv  = {ptick & short_i,
                   s.cnt == 5'h0, full,
                   ptick,
                   ptick && $signed(diff[23:16]) < $signed(s.ths_l),
                   ptick && $signed(diff[23:16]) > $signed(s.ths_h)};

   // -------------------------------------------------------------
   // Core domain
   // -------------------------------------------------------------
   always_comb begin
      n   = s;
      pop = 1'b0;
      n.fr_m = l.tog;
      n.fr_s = s.fr_m;
      n.fr_d = s.fr_s;
      n.ak_m = l.ack;
      n.ak_s = s.ak_m;
      // Snapshot is held still until the link side has taken it
      if (s.ak_s == s.sreq) begin
         n.sreq = ~s.sreq;
         n.snap = {s.tout, head,
                   {2'b00, s.por, s.tor, full, s.cnt == 5'h0,
                    s.pda, s.tda},
                   s.ths_h, s.ths_l,
                   {|s.src, 1'b0, s.src},
                   s.ctrl3, s.ctrl2, s.mask, s.ctrl0,
                   DEV_ID, s.ref_p};
      end
      if (s.ctrl2[AZ_BIT]) begin
         n.ref_p         = s.last_p;
         n.ctrl2[AZ_BIT] = 1'b0;
      end
      if (wr) begin
         case (w.addr)
            A_REF_XL: n.ref_p[7:0]   = w.data;
            A_REF_L:  n.ref_p[15:8]  = w.data;
            A_REF_H:  n.ref_p[23:16] = w.data;
            A_CTRL0:  n.ctrl0 = w.data & 8'h02;
            A_MASK:   n.mask  = w.data & 8'h3f;
            A_CTRL3:  n.ctrl3 = w.data & 8'hf1;
            A_THS_L:  n.ths_l = w.data;
            A_THS_H:  n.ths_h = w.data;
            A_CTRL2:  begin
               if (w.data[SWR_BIT])
                  n = cfg_rst(n);
               else
                  n.ctrl2 = w.data & 8'he2;
            end
            default:  ;
         endcase
      end
      if (rdv) begin
         case (w.addr)
            A_INT:    n.src = 6'h0;
            A_POUT_X: n.rdmask[0] = 1'b1;
            A_POUT_M: n.rdmask[1] = 1'b1;
            A_POUT_H: begin
               n.rdmask[2] = 1'b1;
               n.pda = 1'b0;
               n.por = 1'b0;
            end
            A_TOUT_H: begin
               n.tda = 1'b0;
               n.tor = 1'b0;
            end
            default:  ;
         endcase
         if (&n.rdmask) begin
            n.rdmask = 3'h0;
            pop      = s.cnt != 5'h0;
         end
      end
      // Counters restart whenever the run or chip-on bit is clear
      n.pcnt = (!meas || ptick) ? 26'h0 : s.pcnt + 26'h1;
      n.tcnt = (!meas || ttick) ? 26'h0 : s.tcnt + 26'h1;
      if (pop)
         n.rp = s.rp + 4'h1;
      if (push) begin
         n.fifo[s.wp] = diff;
         n.wp         = s.wp + 4'h1;
         n.last_p     = diff;
         n.pda        = 1'b1;
         if (full) begin
            n.por = 1'b1;
            if (!pop)
               n.rp = s.rp + 4'h1;
         end
      end
      case ({push, pop})
         2'b10:   n.cnt = full ? s.cnt : s.cnt + 5'h1;
         2'b01:   n.cnt = s.cnt - 5'h1;
         default: n.cnt = s.cnt;
      endcase
      if (ttick) begin
         n.tout = raw_temp_i;
         n.tda  = 1'b1;
         if (s.tda)
            n.tor = 1'b1;
      end
      // Events set after the clears, so a new event wins over a read
      // Queue flags follow the level; the others hold until read
      n.src  = {n.src[5] | setv[5], setv[4:3],
                n.src[2:0] | setv[2:0]};
      n.intq = (|(n.src & ~n.mask[5:0])) ^ n.ctrl2[POL_BIT];
   end

   always_ff @(posedge clk) begin
      if (rst)
         s <= cfg_rst('0);
      else if (ce)
         s <= n;
   end

   assign int_o  = s.intq;
   assign int_oe = ~s.ctrl2[TRI_BIT];

   // -------------------------------------------------------------
   // Link domain
   // -------------------------------------------------------------
   function automatic logic [7:0] rdbyte(input logic [6:0] a,
                                         input pzs_link_type x);
      rdbyte = 8'h00;
      if (a >= A_REF_XL && a <= A_REF_H)
         rdbyte = x.snap[5'(a - A_REF_XL)];
      else if (a == A_DEVID)
         rdbyte = x.snap[3];
      else if (a >= A_CTRL0 && a <= A_TOUT_H)
         rdbyte = x.snap[5'(a - A_CTRL0) + 5'h4];
   endfunction : rdbyte

   // Bit counter is cleared by the frame's own select, since the link
   // clock stops between frames
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n)
         lcnt <= 5'h0;
      else if (lcnt < 5'h10)
         lcnt <= lcnt + 5'h1;
   end

   assign din = l.sim_s ? sdio_i : sdi;

   always_comb begin
      m       = l;
      m.sim_m = s.ctrl3[SIM_BIT];
      m.sim_s = l.sim_m;
      m.rq_m  = s.sreq;
      m.rq_s  = l.rq_m;
      if (l.rq_s != l.ack) begin
         m.snap = s.snap;
         m.ack  = l.rq_s;
      end
      m.sh = {l.sh[14:0], din};
      if (lcnt == 5'h7) begin
         m.rd  = m.sh[7];
         m.out = rdbyte(m.sh[6:0], l);
      end else if (lcnt > 5'h7) begin
         m.out = {l.out[6:0], 1'b0};
      end
      if (lcnt == 5'hf) begin
         m.hold = pzs_frame_type'(m.sh);
         m.tog  = ~l.tog;
      end
   end

   // Reset is released while the link clock is idle
   always_ff @(posedge sclk or posedge rst) begin
      if (rst)
         l <= '0;
      else
         l <= m;
   end

   assign rdph    = l.rd && lcnt >= 5'h8 && lcnt < 5'h10;
   assign sdo_o   = l.out[7];
   assign sdio_o  = l.out[7];
   assign sdo_oe  = rdph & ~l.sim_s;
   assign sdio_oe = rdph & l.sim_s;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   property p_swrst;
      @(posedge clk) disable iff (rst)
      (ce && wr && w.addr == A_CTRL2 && w.data[SWR_BIT]) |=>
         (s.mask == MASK_RST && s.ths_h == THS_H_RST && s.ctrl2 == 8'h0);
   endproperty
   a_swrst: assert property (p_swrst)
      else $error("soft reset left configuration changed");

   property p_az;
      @(posedge clk) disable iff (rst)
      (ce && s.ctrl2[AZ_BIT] && !wr) |=>
         (s.ref_p == $past(s.last_p) && !s.ctrl2[AZ_BIT]);
   endproperty
   a_az: assert property (p_az)
      else $error("reference capture wrong or bit stuck");

   property p_diff;
      @(posedge clk) disable iff (rst)
      (ce && push) |=> s.last_p == $past(diff) && s.pda;
   endproperty
   a_diff: assert property (p_diff)
      else $error("result is not pressure minus reference");

   property p_rate;
      @(posedge clk) disable iff (rst)
      ptick |-> (meas && s.pcnt == per - 26'h1);
   endproperty
   a_rate: assert property (p_rate)
      else $error("pressure tick off its period");

   property p_rdclr;
      @(posedge clk) disable iff (rst)
      (ce && rdv && w.addr == A_INT) |=> s.src == $past(setv);
   endproperty
   a_rdclr: assert property (p_rdclr)
      else $error("source read did not clear flags");

   property p_low;
      @(posedge clk) disable iff (rst)
      (ce && push && $signed(diff[23:16]) < $signed(s.ths_l)) |=>
         s.src[1];
   endproperty
   a_low: assert property (p_low)
      else $error("low limit flag missed");

   property p_high;
      @(posedge clk) disable iff (rst)
      (ce && push && $signed(diff[23:16]) > $signed(s.ths_h)) |=>
         s.src[0] ##1 (s.src[0] || $past(rdv));
   endproperty
   a_high: assert property (p_high)
      else $error("high limit flag missed");

   property p_por;
      @(posedge clk) disable iff (rst)
      (ce && push && full) |=> s.por;
   endproperty
   a_por: assert property (p_por)
      else $error("overrun not flagged");

   property p_pop;
      @(posedge clk) disable iff (rst)
      (ce && pop && !push) |=> s.cnt == $past(s.cnt) - 5'h1;
   endproperty
   a_pop: assert property (p_pop)
      else $error("head sample not removed");

   property p_ovw;
      @(posedge clk) disable iff (rst)
      (ce && push && full && !pop) |=>
         (s.cnt == FIFO_FULL && s.rp == $past(s.rp) + 4'h1);
   endproperty
   a_ovw: assert property (p_ovw)
      else $error("oldest sample not dropped");

endmodule : pzs_ctrl

/* File: pzs_ctrl_test.sv */
// Self-checking bench for the pressure sensor control block.
// Assumes pzs_pkg, pzs_ctrl and the host model pzs_host are compiled.
`timescale 1ns/1ps
module pzs_ctrl_test;
   import pzs_pkg::*;
   typedef struct packed {
      logic       w;
      logic [6:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } pzs_row_type;
   logic        clk = 1'b0;
   logic        rst;
   logic        ce = 1'b1;
   logic        short_i = 1'b0;
   logic [23:0] raw_press_i = 24'h123456;
   logic [15:0] raw_temp_i = 16'hbeef;
   logic        sclk, cs_n, sdi, sdio_d, sdio_en, tog = 1'b0, tw = 1'b0;
   logic        sdo_o, sdo_oe, sdio_o, sdio_oe, int_o, int_oe;
   logic [7:0]  q;
   int          num_errors = 0;
   int          checks_done = 0;
   // Released pins show a changing pattern, never the last value
   wire         sdo_w = sdo_oe ? sdo_o : tog;
   wire         sdio_w = sdio_oe ? sdio_o : (sdio_en ? sdio_d : tog);
   pzs_row_type rows [16] = '{
      '{1'b0, A_CTRL0, 8'h00, 8'h00},
      '{1'b0, A_MASK,  8'h00, 8'h3f},
      '{1'b0, A_CTRL2, 8'h00, 8'h00},
      '{1'b0, A_CTRL3, 8'h00, 8'h30},
      '{1'b0, A_THS_L, 8'h00, 8'h00},
      '{1'b0, A_THS_H, 8'h00, 8'hff},
      '{1'b0, A_REF_H, 8'h00, 8'h00},
      '{1'b0, A_DEVID, 8'h00, DEV_ID},
      '{1'b0, A_INT,   8'h00, 8'h90},
      '{1'b0, A_STAT,  8'h00, 8'h04},
      '{1'b1, 7'h10,   8'h55, 8'h00},
      '{1'b1, A_THS_L, 8'h13, 8'h13},
      '{1'b1, A_THS_H, 8'h11, 8'h11},
      '{1'b1, A_REF_XL, 8'ha5, 8'ha5},
      '{1'b1, A_REF_XL, 8'h00, 8'h00},
      '{1'b1, A_CTRL0, 8'hff, 8'h02}};

   always #12.5 clk = ~clk;
   always @(posedge clk) tog <= ~tog;

   pzs_ctrl #(.CYC_1S_P(200), .CYC_5S_P(100), .CYC_11S_P(60),
              .CYC_23S_P(40)) dut (
      .clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sdio_i(sdio_w),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .raw_press_i(raw_press_i),
      .raw_temp_i(raw_temp_i), .short_i(short_i), .int_o(int_o),
      .int_oe(int_oe));

   pzs_host host (
      .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdio_d(sdio_d),
      .sdio_en(sdio_en), .sdo(sdo_w), .sdio(sdio_w));

   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic wait_int(input logic e);
      int n;
      n = 0;
      while (int_o !== e && n < 20) begin
         @(posedge clk);
         n++;
      end
      checks_done++;
      if (int_o !== e) begin
         num_errors++;
         $display("Error int_o expected %b seen %b", e, int_o);
      end
   endtask : wait_int

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.xfer(tw, 1'b0, a, d, r);
   endtask : wr

   // Dummy frame first: read data comes from the previous snapshot
   task automatic rd(input logic [6:0] a, output logic [7:0] r);
      host.xfer(tw, 1'b1, A_DEVID, 8'h00, r);
      host.xfer(tw, 1'b1, a, 8'h00, r);
   endtask : rd

   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] r;
      rd(a, r);
      chk($sformatf("reg %h", a), e, r);
   endtask : rdc

   task automatic end_sim;
      $display("num_errors %0d checks_done %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      $display("Error watchdog expected done seen hang");
      end_sim();
   end

   // ----------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------
   initial begin
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr(rows[i].a, rows[i].d);
         end
         rdc(rows[i].a, rows[i].e);
      end
      // Run bit alone must not start sampling
      wr(A_CTRL0, 8'h00);
      @(posedge clk) short_i <= 1'b1;
      wr(A_CTRL3, 8'hf0);
      repeat (300) @(posedge clk);
      rdc(A_STAT, 8'h04);
      wr(A_CTRL0, 8'h02);
      repeat (800) @(posedge clk);
      wr(A_CTRL3, 8'h70);
      @(posedge clk) short_i <= 1'b0;
      rdc(A_STAT, 8'h3b);
      wait_int(1'b0);
      wr(A_MASK, 8'h3e);
      wait_int(1'b1);
      rdc(A_INT, 8'haf);
      wait_int(1'b0);
      rdc(A_INT, 8'h88);
      rdc(A_TOUT_L, 8'hef);
      rdc(A_TOUT_H, 8'hbe);
      rdc(A_STAT, 8'h2a);
      rdc(A_POUT_X, 8'h56);
      rdc(A_POUT_M, 8'h34);
      rdc(A_POUT_H, 8'h12);
      rdc(A_STAT, 8'h00);
      wr(A_CTRL2, 8'h02);
      rdc(A_CTRL2, 8'h00);
      rdc(A_REF_XL, 8'h56);
      rdc(A_REF_H, 8'h12);
      // Drain the queue so the next sample sits at the head
      for (int i = 0; i < 20; i++) begin
         rd(A_STAT, q);
         if (q[2] === 1'b1) begin
            break;
         end
         host.xfer(tw, 1'b1, A_POUT_X, 8'h00, q);
         host.xfer(tw, 1'b1, A_POUT_M, 8'h00, q);
         host.xfer(tw, 1'b1, A_POUT_H, 8'h00, q);
      end
      rdc(A_STAT, 8'h04);
      @(posedge clk) raw_press_i <= 24'h123500;
      wr(A_CTRL3, 8'hf0);
      repeat (50) @(posedge clk);
      wr(A_CTRL3, 8'h70);
      rdc(A_POUT_X, 8'haa);
      rdc(A_POUT_M, 8'h00);
      rdc(A_POUT_H, 8'h00);
      wr(A_CTRL2, 8'h40);
      wait_int(1'b1);
      wr(A_CTRL2, 8'h04);
      rdc(A_CTRL2, 8'h00);
      rdc(A_MASK, 8'h3f);
      rdc(A_THS_H, 8'hff);
      wait_int(1'b0);
      wr(A_CTRL2, 8'h80);
      chk("int_oe", 8'h00, {7'h00, int_oe});
      wr(A_CTRL3, 8'h31);
      tw = 1'b1;
      rdc(A_DEVID, DEV_ID);
      rdc(A_CTRL3, 8'h31);
      wr(A_THS_L, 8'h13);
      // Hard reset in three-wire mode with sampling stopped, with the link clock idle
      @(posedge clk) rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      tw = 1'b0;
      repeat (4) @(posedge clk);
      wait_int(1'b0);
      chk("int_oe", 8'h01, {7'h00, int_oe});
      rdc(A_CTRL3, 8'h30);
      rdc(A_THS_L, 8'h00);
      rdc(A_STAT, 8'h04);
      end_sim();
   end
endmodule : pzs_ctrl_test

/* File: pzs_host.sv */
// Host model: drives 16-bit link frames toward the sensor block.
// Assumes the bench resolves the output pin and the shared data pin.
`timescale 1ns/1ps
module pzs_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   output logic      sdio_d,
   output logic      sdio_en,
   input  wire logic sdo,
   input  wire logic sdio
);
   // ----------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------
   initial begin
      sclk = 1'b1;
      cs_n = 1'b0;
      sdi = 1'b0;
      sdio_d = 1'b0;
      sdio_en = 1'b0;
      // A rising select clears the bit counter before the first frame
      #1 cs_n = 1'b1;
   end

   // Link clock stands high between frames; data moves on the fall
   task automatic xfer(input logic tw, input logic rd, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [15:0] w;
      w = {rd, a, d};
      q = 8'h00;
      cs_n = 1'b0;
      sdio_en = tw;
      for (int j = 1; j <= 16; j++) begin
         #3;
         sclk = 1'b0;
         // Let go of the shared pin only once the device drives it,
         // so the last address bit is not raced at the eighth rise
         if (rd && j == 9) begin
            sdio_en = 1'b0;
         end
         if (j >= 9) begin
            q = {q[6:0], (tw ? sdio : sdo)};
         end
         sdi = w[16-j];
         sdio_d = w[16-j];
         #3;
         sclk = 1'b1;
      end
      #3;
      cs_n = 1'b1;
      sdio_en = 1'b0;
      sdi = ~sdi;
      #150;
   endtask : xfer
endmodule : pzs_host

/* File: pzs_pkg.sv */
// Constants and state types of the pressure sensor control block.
// Assumes one core clock and a serial link clocked by the host.
package pzs_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ  = 40_000_000;
   localparam int unsigned RATE_1  = 1;
   localparam int unsigned RATE_5  = 5;
   localparam int unsigned RATE_11 = 11;
   localparam int unsigned RATE_23 = 23;
   localparam int unsigned CYC_1S  = CLK_HZ / RATE_1;
   localparam int unsigned CYC_5S  = CLK_HZ / RATE_5;
   localparam int unsigned CYC_11S = CLK_HZ / RATE_11;
   localparam int unsigned CYC_23S = CLK_HZ / RATE_23;

   // -------------------------------------------------------------
   // Register addresses
   // -------------------------------------------------------------
   localparam logic [6:0] A_REF_XL = 7'h08;
   localparam logic [6:0] A_REF_L  = 7'h09;
   localparam logic [6:0] A_REF_H  = 7'h0a;
   localparam logic [6:0] A_DEVID  = 7'h0f;
   localparam logic [6:0] A_CTRL0  = 7'h20;
   localparam logic [6:0] A_MASK   = 7'h21;
   localparam logic [6:0] A_CTRL2  = 7'h22;
   localparam logic [6:0] A_CTRL3  = 7'h23;
   localparam logic [6:0] A_INT    = 7'h24;
   localparam logic [6:0] A_THS_L  = 7'h25;
   localparam logic [6:0] A_THS_H  = 7'h26;
   localparam logic [6:0] A_STAT   = 7'h27;
   localparam logic [6:0] A_POUT_X = 7'h28;
   localparam logic [6:0] A_POUT_M = 7'h29;
   localparam logic [6:0] A_POUT_H = 7'h2a;
   localparam logic [6:0] A_TOUT_L = 7'h2b;
   localparam logic [6:0] A_TOUT_H = 7'h2c;

   // -------------------------------------------------------------
   // Fields and reset values
   // -------------------------------------------------------------
   localparam int EN_BIT   = 1;
   localparam int AZ_BIT   = 1;
   localparam int SWR_BIT  = 2;
   localparam int POL_BIT  = 6;
   localparam int TRI_BIT  = 7;
   localparam int RUN_BIT  = 7;
   localparam int SIM_BIT  = 0;
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] MASK_RST  = 8'h3f;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] CTRL3_RST = 8'h30;
   localparam logic [7:0] THS_L_RST = 8'h00;
   localparam logic [7:0] THS_H_RST = 8'hff;
   localparam logic [7:0] DEV_ID    = 8'h5a; // Arbitrary value
   localparam logic [4:0] FIFO_FULL = 5'h10;
   localparam int         N_SNAP    = 17;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic [6:0] addr;
      logic [7:0] data;
   } pzs_frame_type;

   typedef struct packed {
      logic [23:0]             ref_p;
      logic [7:0]              ctrl0, mask, ctrl2, ctrl3, ths_l, ths_h;
      logic [5:0]              src;
      logic                    pda, tda, por, tor, intq;
      logic [15:0][23:0]       fifo;
      logic [3:0]              wp, rp;
      logic [4:0]              cnt;
      logic [2:0]              rdmask;
      logic [15:0]             tout;
      logic [23:0]             last_p;
      logic [25:0]             pcnt, tcnt;
      logic                    fr_m, fr_s, fr_d, ak_m, ak_s, sreq;
      logic [N_SNAP-1:0][7:0]  snap;
   } pzs_core_type;

   typedef struct packed {
      logic [15:0]             sh;
      logic [7:0]              out;
      logic                    rd, sim_m, sim_s, rq_m, rq_s, ack, tog;
      pzs_frame_type           hold;
      logic [N_SNAP-1:0][7:0]  snap;
   } pzs_link_type;

endpackage : pzs_pkg
